// *** common/fpwm_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock
// Notes:   Included by its bare name
`ifndef FPWM_PARAMS_SVH
`define FPWM_PARAMS_SVH
`define FPWM_REG_CTRL      8'h7a
`define FPWM_REG_LOAD      8'hbc
`define FPWM_CTRL_CNT_RST  0
`define FPWM_CTRL_TRIG     1
`define FPWM_CTRL_RESET    8'h00
`define FPWM_LOAD_RESET    8'h00
`define FPWM_I2C_ADDR      7'h08
`define FPWM_CLK_HZ        20000000
`define FPWM_BASE_DIV      8
`define FPWM_PERIOD        256
`define FPWM_DEBOUNCE_MS   20
`define FPWM_DEBOUNCE_CYC  ((`FPWM_CLK_HZ / 1000) * `FPWM_DEBOUNCE_MS)
`endif

// *** common/fpwm_pkg.sv ***
// Purpose: Types shared by the fan PWM block
// Assumes: Nothing
// Notes:   Serial slave state lives here
package fpwm_pkg;
    typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_DATA} fpwm_i2c_st_t;
    typedef struct packed {
        fpwm_i2c_st_t st;
        logic [1:0]   scl_s;
        logic [1:0]   sda_s;
        logic         scl_d;
        logic         sda_d;
        logic [3:0]   bits;
        logic [7:0]   sh;
        logic [7:0]   ptr;
        logic         ackph;
        logic         oe;
        logic         wr;
        logic [7:0]   wdata;
        logic [7:0]   waddr;
    } fpwm_i2c_state_t;
endpackage

// *** common/fpwm_regs_if.sv ***
// Purpose: Register write strobe from the serial slave to the core
// Assumes: One clock domain
// Notes:   wr_en is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface fpwm_regs_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    modport slave (output wr_en, output wr_addr, output wr_data);
    modport core  (input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// *** design/fpwm_i2c_slave.sv ***
// Purpose: Write-only serial register slave
// Assumes: Bus far slower than clk, open-drain data line
// Notes:   Register pointer auto-increments
`timescale 1ns/1ns
`default_nettype none
`include "fpwm_params.svh"
module fpwm_i2c_slave
    import fpwm_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    reset,
    input  wire logic    scl_i,
    input  wire logic    sda_i,
    output logic         sda_o,
    output logic         sda_oe,
    fpwm_regs_if.slave   regs
);
    fpwm_i2c_state_t q, d;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    assign scl_rise = q.scl_s[1] & ~q.scl_d;
    assign scl_fall = ~q.scl_s[1] & q.scl_d;
    assign start_ev = q.scl_s[1] & q.scl_d & q.sda_d & ~q.sda_s[1];
    assign stop_ev  = q.scl_s[1] & q.scl_d & ~q.sda_d & q.sda_s[1];

    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[0], scl_i};
        d.sda_s = {q.sda_s[0], sda_i};
        d.scl_d = q.scl_s[1];
        d.sda_d = q.sda_s[1];
        d.wr = 1'b0;
        if (start_ev) begin
            d.st = I2C_ADDR;
            d.bits = 4'h0;
            d.ackph = 1'b0;
            d.oe = 1'b0;
        end else if (stop_ev) begin
            d.st = I2C_IDLE;
            d.oe = 1'b0;
            d.ackph = 1'b0;
        end else if (q.st != I2C_IDLE) begin
            if (scl_rise && !q.ackph && q.bits != 4'h8) begin
                d.sh = {q.sh[6:0], q.sda_s[1]};
                d.bits = q.bits + 4'h1;
            end
            if (scl_fall) begin
                if (q.ackph) begin
                    d.ackph = 1'b0;
                    d.oe = 1'b0;
                end else if (q.bits == 4'h8) begin
                    d.bits = 4'h0;
                    d.ackph = 1'b1;
                    d.oe = 1'b1;
                    unique case (q.st)
                        I2C_ADDR: begin
                            // Reads are not served: no acknowledge
                            if (q.sh[7:1] == `FPWM_I2C_ADDR && !q.sh[0]) begin
                                d.st = I2C_PTR;
                            end else begin
                                d.st = I2C_IDLE;
                                d.ackph = 1'b0;
                                d.oe = 1'b0;
                            end
                        end
                        I2C_PTR: begin
                            d.ptr = q.sh;
                            d.st = I2C_DATA;
                        end
                        I2C_DATA: begin
                            d.wr = 1'b1;
                            d.waddr = q.ptr;
                            d.wdata = q.sh;
                            d.ptr = q.ptr + 8'h01;
                        end
                        I2C_IDLE: d.st = I2C_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.st <= I2C_IDLE;
            q.scl_s <= 2'h3;
            q.sda_s <= 2'h3;
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = q.oe;
    assign regs.wr_en = q.wr;
    assign regs.wr_addr = q.waddr;
    assign regs.wr_data = q.wdata;
endmodule
`default_nettype wire

// *** design/fpwm_top.sv ***
// Purpose: Fan PWM from two offset counters, rotary and serial duty control
// Assumes: 20 MHz clk, rotary pulses and button asynchronous
// Notes:   Fast injection clock is clk itself while the one-shot runs
`timescale 1ns/1ns
`default_nettype none
`include "fpwm_params.svh"

// What this block does
// - Set and reset counters drive output flop
// - Inverted reset counter output clears flop
// - Clockwise pulse injects one set-counter clock
// - Counterclockwise pulse skips one set-counter clock
// - Reset counter gets undisturbed base clock
// - Lookup picks set clock from base/injected
// - Debounce button 20 ms, press toggles select
// - Unselected chip passes only base and one-shot clocks
// - Latches block steps one clock before rollover
// - Delayed copies of set and reset outputs
// - Delayed set meets reset: block decrease
// - Reset delayed two meets set: block increase
// - Control bit 0 holds both counters reset
// - Load register sets one-shot length
// - Control bit 1 triggers one-shot
// - Falling-edge pulse clocks trigger sync flop
// - One-shot gates exactly loaded fast clocks
module fpwm_top
    import fpwm_pkg::*;
#(
    parameter int PERIOD          = `FPWM_PERIOD,
    parameter int DEBOUNCE_CYCLES = `FPWM_DEBOUNCE_CYC
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic rotate_up_pulse,
    input  wire logic rotate_down_pulse,
    input  wire logic button_i,
    output logic      pwm_out,
    output logic      selected_o
);
    localparam int CNT_W = $clog2(PERIOD);
    localparam int DBW   = $clog2(DEBOUNCE_CYCLES + 1);

    if (PERIOD < 4 || PERIOD > 65536) begin : g_chk_period
        $error("PERIOD out of range");
    end
    if (DEBOUNCE_CYCLES < 2) begin : g_chk_deb
        $error("DEBOUNCE_CYCLES too small");
    end

    typedef struct packed {
        logic [2:0]     div;
        logic [1:0]     btn_s;
        logic [1:0]     up_s;
        logic [1:0]     dn_s;
        logic           up_d;
        logic           dn_d;
        logic [DBW-1:0] deb_cnt;
        logic           btn_st;
        logic           sel;
        logic           inj_pend;
        logic           skip_pend;
        logic [CNT_W-1:0] set_cnt;
        logic [CNT_W-1:0] rst_cnt;
        logic           set_out;
        logic           rst_out_n;
        logic           set_hit;
        logic           set_dly;
        logic           rst_dly1;
        logic           rst_dly2;
        logic           blk_inc;
        logic           blk_dec;
        logic           pwm;
        logic [7:0]     ctrl;
        logic [7:0]     load;
        logic           trg_sync;
        logic           trg_d;
        logic [7:0]     os_cnt;
    } fpwm_core_t;

    fpwm_core_t q, d;
    fpwm_regs_if regs ();

    fpwm_i2c_slave fpwm_i2c_slave_inst (
        .clk    (clk),
        .reset  (reset),
        .scl_i  (scl_i),
        .sda_i  (sda_i),
        .sda_o  (sda_o),
        .sda_oe (sda_oe),
        .regs   (regs)
    );

    logic         base_tick, base_fall, up_edge, dn_edge, os_active, cnt_hold;
    logic         fire, do_inj, do_skip;
    logic [1:0]   step;
    logic [CNT_W:0] set_sum;
    logic         set_wrap, rst_wrap;

    assign base_tick = (q.div == 3'(`FPWM_BASE_DIV - 1));
    assign base_fall = (q.div == 3'(`FPWM_BASE_DIV / 2 - 1));
    assign up_edge   = q.up_s[1] & ~q.up_d;
    assign dn_edge   = q.dn_s[1] & ~q.dn_d;
    assign os_active = (q.os_cnt != 8'h00);
    assign cnt_hold  = q.ctrl[`FPWM_CTRL_CNT_RST];
    assign fire      = q.trg_sync & ~q.trg_d;
    assign do_inj    = q.inj_pend & q.sel;
    // skip waits for the next base edge
    assign do_skip   = q.skip_pend & q.sel & base_tick;

    always_comb begin
        step = '0;
        if (base_tick && !do_skip) begin
            step = step + 2'd1;
        end
        if (do_inj) begin
            step = step + 2'd1;
        end
        if (os_active) begin
            step = step + 2'd1;
        end
    end

    assign set_sum  = {1'b0, q.set_cnt} + (CNT_W+1)'(step);
    assign set_wrap = (set_sum >= (CNT_W+1)'(PERIOD));
    assign rst_wrap = base_tick && (q.rst_cnt == CNT_W'(PERIOD - 1));

    always_comb begin
        d = q;
        d.div = q.div + 3'd1;
        d.btn_s = {q.btn_s[0], button_i};
        d.up_s = {q.up_s[0], rotate_up_pulse};
        d.dn_s = {q.dn_s[0], rotate_down_pulse};
        d.up_d = q.up_s[1];
        d.dn_d = q.dn_s[1];

        if (q.btn_s[1] != q.btn_st) begin
            d.deb_cnt = q.deb_cnt + DBW'(1);
            if (q.deb_cnt == DBW'(DEBOUNCE_CYCLES - 1)) begin
                d.deb_cnt = '0;
                d.btn_st = q.btn_s[1];
                d.sel = q.sel ^ q.btn_s[1];
            end
        end else begin
            d.deb_cnt = '0;
        end

        // Consumed steps clear first, so a new edge in the same cycle survives
        if (do_inj) begin
            d.inj_pend = 1'b0;
        end
        if (do_skip) begin
            d.skip_pend = 1'b0;
        end
        // blocked requests never reach the lookup
        if (q.sel && up_edge && !q.blk_inc) begin
            d.inj_pend = 1'b1;
        end
        if (q.sel && dn_edge && !q.blk_dec) begin
            d.skip_pend = 1'b1;
        end
        if (!q.sel) begin
            d.inj_pend = 1'b0;
            d.skip_pend = 1'b0;
        end

        d.set_cnt = set_wrap ? CNT_W'(set_sum - (CNT_W+1)'(PERIOD)) : set_sum[CNT_W-1:0];
        d.set_out = set_wrap;
        // reset counter on base clock only
        if (base_tick) begin
            d.rst_cnt = rst_wrap ? '0 : q.rst_cnt + CNT_W'(1);
        end
        d.rst_out_n = ~rst_wrap;

        if (!q.rst_out_n) begin
            d.pwm = 1'b0;
        end else if (q.set_out) begin
            d.pwm = 1'b1;
        end

        d.set_hit = q.set_hit | set_wrap;
        if (base_tick) begin
            d.set_hit = 1'b0;
            d.set_dly = q.set_hit | set_wrap;
            d.rst_dly1 = rst_wrap;
            d.rst_dly2 = q.rst_dly1;
            if (q.set_dly && rst_wrap) begin
                d.blk_dec = 1'b1;
            end
            if (q.rst_dly2 && (q.set_hit || set_wrap)) begin
                d.blk_inc = 1'b1;
            end
        end
        // Stepping the other way frees the latch
        if (do_inj || os_active) begin
            d.blk_dec = 1'b0;
        end
        if (do_skip) begin
            d.blk_inc = 1'b0;
        end

        if (base_fall) begin
            d.trg_sync = q.ctrl[`FPWM_CTRL_TRIG];
        end
        d.trg_d = q.trg_sync;
        if (os_active) begin
            d.os_cnt = q.os_cnt - 8'h01;
        end
        if (fire) begin
            d.os_cnt = q.load;
        end

        if (regs.wr_en && regs.wr_addr == `FPWM_REG_CTRL) begin
            d.ctrl = regs.wr_data;
        end
        if (regs.wr_en && regs.wr_addr == `FPWM_REG_LOAD) begin
            d.load = regs.wr_data;
        end

        if (cnt_hold) begin
            d.set_cnt = '0;
            d.rst_cnt = '0;
            d.set_out = 1'b0;
            d.rst_out_n = 1'b1;
            d.set_hit = 1'b0;
            d.blk_inc = 1'b0;
            d.blk_dec = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.rst_out_n <= 1'b1;
            q.ctrl <= `FPWM_CTRL_RESET;
            q.load <= `FPWM_LOAD_RESET;
        end else begin
            q <= d;
        end
    end

    assign pwm_out = q.pwm;
    assign selected_o = q.sel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_pwm_clear: assert property (!q.rst_out_n |=> !q.pwm)
        else $error("pwm not cleared by reset counter");
    a_pwm_set: assert property (q.set_out && q.rst_out_n |=> q.pwm)
        else $error("pwm not set by set counter");
    a_reset_steady: assert property (!cnt_hold && !base_tick |=> $stable(q.rst_cnt))
        else $error("reset counter moved off base clock");
    a_hold_zero: assert property (cnt_hold |=> q.set_cnt == '0 && q.rst_cnt == '0)
        else $error("counters not held");
    a_inject_once: assert property (do_inj |=> !q.inj_pend [*2])
        else $error("rotary step repeated");
    a_skip_once: assert property (do_skip |=> !q.skip_pend)
        else $error("rotary skip repeated");
    a_unsel_base: assert property (!q.sel |=> !q.inj_pend && !q.skip_pend)
        else $error("step while unselected");
    a_block_dec: assert property (q.blk_dec && !q.skip_pend && !cnt_hold |=> !q.skip_pend)
        else $error("decrease passed while blocked");
    a_block_inc: assert property (q.blk_inc && !q.inj_pend && !cnt_hold |=> !q.inj_pend)
        else $error("increase passed while blocked");
    a_trig_sample: assert property (base_fall |=> q.trg_sync == $past(q.ctrl[1]))
        else $error("trigger not sampled on falling pulse");
    a_gate_pulse_len: assert property (fire |=> q.os_cnt == $past(q.load))
        else $error("one-shot not loaded");
    a_gate_pulse_run: assert property (os_active && !fire |=> q.os_cnt == $past(q.os_cnt) - 8'h01)
        else $error("one-shot miscounted");
    a_skip_apply: assert property (do_skip && !os_active && !cnt_hold |=> q.set_cnt == $past(q.set_cnt))
        else $error("skip did not hold set counter");

    c_inject: cover property (do_inj);
    c_skip: cover property (do_skip);
    c_gate_pulse: cover property (fire ##1 os_active);
    c_block: cover property (q.blk_inc || q.blk_dec);
endmodule
`default_nettype wire

// *** sim/fpwm_partner.sv ***
// Purpose: Far side of the fan PWM block: serial host and rotary decoder
// Assumes: Driven from the bench clock, all changes just after a rising edge
// Notes:   Rotary pulses are far shorter than the real ones to keep runs short
`timescale 1ns/1ns
`default_nettype none
module fpwm_partner #(
    parameter int HALF    = 8,
    parameter int LOW_GAP = 160
) (
    input  wire logic clk,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_low,
    output var logic  up_pulse,
    output var logic  down_pulse
);
    initial begin
        scl        = 1'b1;
        sda_low    = 1'b0;
        up_pulse   = 1'b0;
        down_pulse = 1'b0;
    end

    task automatic hold();
        repeat (HALF) @(posedge clk);
    endtask

    // Data only moves while the serial clock is low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low <= ~b[i];
            hold();
            scl <= 1'b1;
            hold();
            scl <= 1'b0;
            hold();
        end
        sda_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        ack = ~sda_line;
        scl <= 1'b0;
        hold();
    endtask

    task automatic write_reg(input logic [7:0] dev, input logic [7:0] adr,
                             input logic [7:0] data, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        sda_low <= 1'b1;
        hold();
        scl <= 1'b0;
        hold();
        put_byte(dev, a0);
        put_byte(adr, a1);
        put_byte(data, a2);
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
        ok = a0 & a1 & a2;
    endtask

    task automatic rotate(input logic up, input int len);
        if (up) begin
            up_pulse <= 1'b1;
        end else begin
            down_pulse <= 1'b1;
        end
        repeat (len) @(posedge clk);
        up_pulse   <= 1'b0;
        down_pulse <= 1'b0;
        repeat (LOW_GAP) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** sim/fan_pwm_offset_counter_ctrl_tb.sv ***
// Purpose: Self-checking bench for the fan PWM block
// Assumes: Short period and debounce parameters, clk as fast oscillator
// Notes:   Duty is judged as high cycles within one full PWM period
`timescale 1ns/1ns
`default_nettype none
`include "fpwm_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fan_pwm_offset_counter_ctrl_tb;
    localparam int PER  = 16;
    localparam int DEB  = 8;
    localparam int SPAN = PER * `FPWM_BASE_DIV;
    localparam logic [7:0] DEV = {`FPWM_I2C_ADDR, 1'b0};
    logic clk;
    logic reset;
    logic button_i;
    logic sda_o;
    logic sda_oe;
    logic pwm_out;
    logic selected_o;
    logic scl;
    logic host_low;
    logic up_p;
    logic down_p;
    logic sda_line;
    logic ok;
    int   n_errors;
    int   n_tests;
    int   model_off;
    int   hi;
    int   n;

    // Open-drain data line with pull-up
    assign sda_line = ~(host_low | (sda_oe & ~sda_o));

    fpwm_top #(.PERIOD(PER), .DEBOUNCE_CYCLES(DEB)) fpwm_top_inst (
        .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .rotate_up_pulse(up_p), .rotate_down_pulse(down_p),
        .button_i(button_i), .pwm_out(pwm_out), .selected_o(selected_o));

    fpwm_partner fpwm_partner_inst (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low),
        .up_pulse(up_p), .down_pulse(down_p));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Two periods to settle, then count one period
    task automatic measure();
        repeat (2 * SPAN) @(posedge clk);
        hi = 0;
        repeat (SPAN) begin
            @(negedge clk);
            if (pwm_out === 1'b1) hi++;
        end
        @(posedge clk);
    endtask

    task automatic press();
        button_i <= 1'b1;
        repeat (DEB * 3) @(posedge clk);
        button_i <= 1'b0;
        repeat (DEB * 3) @(posedge clk);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        reset     = 1'b1;
        button_i  = 1'b0;
        n_errors  = 0;
        n_tests   = 0;
        model_off = 0;
        void'($urandom(32'h46b5));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        fpwm_partner_inst.write_reg(DEV, `FPWM_REG_CTRL, 8'h01, ok);
        `CHK(ok, 1'b1)
        fpwm_partner_inst.write_reg(DEV, `FPWM_REG_CTRL, 8'h00, ok);
        measure();
        `CHK(hi, 0)
        n = 2 + $urandom % 6;
        fpwm_partner_inst.write_reg(DEV, `FPWM_REG_LOAD, n[7:0], ok);
        fpwm_partner_inst.write_reg(DEV, `FPWM_REG_CTRL, 8'h02, ok);
        fpwm_partner_inst.write_reg(DEV, `FPWM_REG_CTRL, 8'h00, ok);
        model_off = n;
        measure();
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        fpwm_partner_inst.write_reg(DEV + 8'h02, `FPWM_REG_LOAD, 8'hff, ok);
        `CHK(ok, 1'b0)
        fpwm_partner_inst.rotate(1'b1, 20 + $urandom % 40);
        measure();
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        press();
        `CHK(selected_o, 1'b1)
        fpwm_partner_inst.rotate(1'b1, 2 * SPAN);
        model_off++;
        measure();
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        fpwm_partner_inst.rotate(1'b0, 20 + $urandom % 40);
        model_off--;
        measure();
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        // steps past minimum are held off
        repeat (model_off + 3) fpwm_partner_inst.rotate(1'b0, 20 + $urandom % 40);
        measure();
        model_off = 1;
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        repeat (PER + 2) fpwm_partner_inst.rotate(1'b1, 20 + $urandom % 40);
        measure();
        model_off = PER - 2;
        `CHK(hi, model_off * `FPWM_BASE_DIV)
        press();
        `CHK(selected_o, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
